/* File: logic/slrs_consts.svh */
// register offsets, bit positions, reset values and timing counts for the low-power/reset unit
`ifndef SLRS_CONSTS_SVH
`define SLRS_CONSTS_SVH
`define SLRS_ADDR_RSTAT 4'h0
`define SLRS_ADDR_BFCTL 4'h1
`define SLRS_ADDR_BSTAT 4'h2
`define SLRS_ADDR_CFG1 4'h3
`define SLRS_BIT_BREAK_CLEAR_ENABLE 7
`define SLRS_BIT_LPBRK 1
`define SLRS_BIT_SHORT_STOP_RECOVERY 0
`define SLRS_BIT_OSCSTOP 1
`define SLRS_BIT_WDDIS 2
`define SLRS_BFCTL_RESET 8'h00
`define SLRS_CFG1_RESET 8'h00
`define SLRS_RSTAT_POR 8'h80
`define SLRS_LONG_REC 13'h1000
`define SLRS_SHORT_REC 13'h0020
`define SLRS_QUAD_DIV 2'h3
`endif

/* File: logic/slrs_pkg.sv */
// types shared by the low-power/reset unit
package slrs_pkg;
   typedef enum logic [1:0] {
      SLRS_RUN = 2'b00,
      SLRS_WAIT = 2'b01,
      SLRS_STOP = 2'b10,
      SLRS_RECOVER = 2'b11
   } slrs_mode_t;
   // reset sources: bit 7 power-on .. bit 1 low voltage, bit 0 unused
   typedef struct packed {
      logic power_on;
      logic pin;
      logic watchdog;
      logic bad_opcode;
      logic bad_address;
      logic monitor_entry;
      logic low_voltage;
      logic spare;
   } slrs_rst_src_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } slrs_bus_t;
endpackage

/* File: logic/slrs_unit.sv */
// wait/stop control, break flag protection and reset cause capture
// Summary of operation
// - all reset sources equal, highest priority; no arbitration between them
// - break interrupt forces cpu to the software-interrupt vector
// - in break, peripheral flags clear only when break clear enable is set
// - a flag cleared in break stays cleared after break
// - two-step clears protected in break even if step one came earlier
// - wait and stop both clear the global interrupt mask
// - wait stops cpu clocks, peripheral clocks keep running
// - enabled interrupt wakes wait; stacking one cycle after wake
// - reset or break ends wait; break in wait sets lowpower break flag
// - watchdog stays enabled in wait when watchdog disable is 0
// - stop resets recovery counter, stops double clock and, unless osc run, quad clock; irq/reset/break exit
// - osc run in stop keeps quad clock running in stop
// - recovery is 4096 quad cycles, or 32 with short recovery set
// - interrupt stacking starts only after recovery fully elapses
// - recovery counter held reset from stop until recovery begins
// - reset cause register clears all flags after a read
// - power-on sets its flag, clears others; others set only their own
// - several flags may be set together, one per reset source
// - monitor flag set on erased reset vector with irq not at test voltage
`include "slrs_consts.svh"
module slrs_unit
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // register port
   input wire slrs_pkg::slrs_bus_t bus_in,
   output logic [7:0] rdata_out,
   // cpu side
   input wire logic wait_exec_in,
   input wire logic stop_exec_in,
   input wire logic irq_pending_in,
   input wire logic break_irq_in,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic clk_double_en_out,
   output logic clk_quad_en_out,
   output logic clr_int_mask_out,
   output logic force_swi_vector_out,
   output logic stack_start_out,
   output logic break_mode_out,
   output logic watchdog_run_out,
   // peripheral flag clearing
   input wire logic flag_clear_req_in,
   output logic flag_clear_allow_out,
   // reset sources, asynchronous pins
   input wire slrs_pkg::slrs_rst_src_t rst_src_in,
   input wire logic vector_erased_in,
   input wire logic irq_at_test_volt_in,
   output logic sys_reset_out
);
   logic [7:0] rst_sync1;
   logic [7:0] rst_sync2;
   logic [1:0] mon_sync1;
   logic [1:0] mon_sync2;
   logic [7:0] reset_cause_status;
   logic [7:0] break_flag_ctrl_reg;
   logic [7:0] cfg_reg;
   logic break_during_lowpower_flag;
   logic break_mode;
   slrs_pkg::slrs_mode_t mode;
   slrs_pkg::slrs_mode_t next_mode;
   logic [12:0] rec_cnt;
   logic [12:0] rec_target;
   logic [1:0] quad_div;
   logic quad_tick;
   logic rec_done;
   logic any_reset;
   logic irq_wake;
   logic stacked_after_rec;
   logic rd_rstat;

   // external sources are synchronised before use
   always_ff @(posedge mclk_in)
   begin
      rst_sync1 <= rst_src_in;
      rst_sync2 <= rst_sync1;
      mon_sync1 <= {vector_erased_in, irq_at_test_volt_in};
      mon_sync2 <= mon_sync1;
   end

   // any source resets the system alike, no priority among them
   assign any_reset = |rst_sync2[7:1] | (mon_sync2[1] & ~mon_sync2[0]);
   assign sys_reset_out = any_reset;

   // quad-clock enable divider; keeps running in stop only with osc run
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
         quad_div <= 2'h0;
      else if (clk_quad_en_out)
         quad_div <= (quad_div == `SLRS_QUAD_DIV) ? 2'h0 : quad_div + 2'h1;
   end
   // recovery counts on the divided tick so it tracks quad-clock cycles
   assign quad_tick = (quad_div == `SLRS_QUAD_DIV);

   assign rec_target = cfg_reg[`SLRS_BIT_SHORT_STOP_RECOVERY] ? `SLRS_SHORT_REC : `SLRS_LONG_REC;
   assign rec_done = (mode == slrs_pkg::SLRS_RECOVER) && (rec_cnt == rec_target - 13'h1)
      && quad_tick;
   assign irq_wake = irq_pending_in | break_irq_in;

   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         slrs_pkg::SLRS_RUN:
         begin
            if (stop_exec_in)
               next_mode = slrs_pkg::SLRS_STOP;
            else if (wait_exec_in)
               next_mode = slrs_pkg::SLRS_WAIT;
         end
         slrs_pkg::SLRS_WAIT:
         begin
            if (irq_wake)
               next_mode = slrs_pkg::SLRS_RUN;
         end
         slrs_pkg::SLRS_STOP:
         begin
            if (irq_wake)
               next_mode = slrs_pkg::SLRS_RECOVER;
         end
         slrs_pkg::SLRS_RECOVER:
         begin
            if (rec_done)
               next_mode = slrs_pkg::SLRS_RUN;
         end
      endcase
   end

   // reset exits every low-power mode
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in || any_reset)
         mode <= slrs_pkg::SLRS_RUN;
      else
         mode <= next_mode;
   end

   // counter held clear from stop until recovery begins
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in || mode != slrs_pkg::SLRS_RECOVER)
         rec_cnt <= 13'h0000;
      else if (quad_tick)
         rec_cnt <= rec_cnt + 13'h0001;
   end

   // clock gating
   assign cpu_clk_en_out = (mode == slrs_pkg::SLRS_RUN);
   assign periph_clk_en_out = (mode == slrs_pkg::SLRS_RUN) || (mode == slrs_pkg::SLRS_WAIT)
      || (mode == slrs_pkg::SLRS_RECOVER);
   assign clk_double_en_out = (mode != slrs_pkg::SLRS_STOP);
   assign clk_quad_en_out = (mode != slrs_pkg::SLRS_STOP)
      || cfg_reg[`SLRS_BIT_OSCSTOP];
   assign clr_int_mask_out = (mode == slrs_pkg::SLRS_RUN)
      && (wait_exec_in || stop_exec_in);
   assign watchdog_run_out = !cfg_reg[`SLRS_BIT_WDDIS]
      && (mode != slrs_pkg::SLRS_STOP);

   // stacking: one cycle after wake from wait, or once recovery ends
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
         stacked_after_rec <= 1'b0;
      else
         stacked_after_rec <= ((mode == slrs_pkg::SLRS_WAIT) && irq_wake) || rec_done;
   end
   assign stack_start_out = stacked_after_rec;

   // break entry forces the software-interrupt vector
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         force_swi_vector_out <= 1'b0;
         break_mode <= 1'b0;
      end
      else
      begin
         force_swi_vector_out <= break_irq_in && !break_mode;
         if (break_irq_in)
            break_mode <= 1'b1;
         else if (!break_irq_in && stack_start_out == 1'b0 && mode == slrs_pkg::SLRS_RUN)
            break_mode <= 1'b0;
      end
   end
   assign break_mode_out = break_mode;

   // break in wait, stop or recovery; set wins over the clearing write
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
         break_during_lowpower_flag <= 1'b0;
      else if (break_irq_in && (mode != slrs_pkg::SLRS_RUN))
         break_during_lowpower_flag <= 1'b1;
      else if (bus_in.wr && bus_in.addr == `SLRS_ADDR_BSTAT
         && !bus_in.wdata[`SLRS_BIT_LPBRK])
         break_during_lowpower_flag <= 1'b0;
   end

   // clears gated in break; a granted clear is final, and a second step
   // after break proceeds normally since only the clearing access is gated
   assign flag_clear_allow_out = flag_clear_req_in
      && (!break_mode || break_flag_ctrl_reg[`SLRS_BIT_BREAK_CLEAR_ENABLE]);

   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         break_flag_ctrl_reg <= `SLRS_BFCTL_RESET;
         cfg_reg <= `SLRS_CFG1_RESET;
      end
      else if (bus_in.wr)
      begin
         if (bus_in.addr == `SLRS_ADDR_BFCTL)
            break_flag_ctrl_reg <= {bus_in.wdata[`SLRS_BIT_BREAK_CLEAR_ENABLE], 7'h00};
         // bit 0 short recovery, bit 1 quad clock in stop, bit 2 watchdog off
         if (bus_in.addr == `SLRS_ADDR_CFG1)
            cfg_reg <= {5'h00, bus_in.wdata[2:0]};
      end
   end

   // reset cause capture; new causes win over the read clear
   assign rd_rstat = bus_in.rd && (bus_in.addr == `SLRS_ADDR_RSTAT);
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
         reset_cause_status <= `SLRS_RSTAT_POR;
      else if (rst_sync2[7])
         reset_cause_status <= `SLRS_RSTAT_POR;
      else
         reset_cause_status <= (rd_rstat ? 8'h00 : reset_cause_status)
            | {1'b0, rst_sync2[6:3],
               rst_sync2[2] | (mon_sync2[1] & ~mon_sync2[0]),
               rst_sync2[1], 1'b0};
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in || !bus_in.rd)
         rdata_out <= 8'h00;
      else
         unique case (bus_in.addr)
            `SLRS_ADDR_RSTAT: rdata_out <= reset_cause_status;
            `SLRS_ADDR_BFCTL: rdata_out <= break_flag_ctrl_reg;
            `SLRS_ADDR_BSTAT: rdata_out <= {6'h00, break_during_lowpower_flag, 1'b0};
            `SLRS_ADDR_CFG1: rdata_out <= cfg_reg;
            default: rdata_out <= 8'h00;
         endcase
   end

   // cycles spent in recovery, counted apart from the divider as a yardstick
   logic [14:0] rec_len;
   logic [14:0] rec_span;
   assign rec_span = {rec_target, 2'b00};
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in || mode != slrs_pkg::SLRS_RECOVER)
         rec_len <= 15'h0000;
      else
         rec_len <= rec_len + 15'h0001;
   end

   // single steps of the wait and stop flows
   sequence seq_wait_entry;
      mode == slrs_pkg::SLRS_RUN && wait_exec_in && !stop_exec_in;
   endsequence
   sequence seq_wait_break;
      mode == slrs_pkg::SLRS_WAIT && break_irq_in;
   endsequence
   sequence seq_stop_wake;
      mode == slrs_pkg::SLRS_STOP && irq_wake;
   endsequence
   sequence seq_rec_end;
      mode == slrs_pkg::SLRS_RECOVER && rec_done;
   endsequence

   // clock gating in run, wait and stop, wait entry and watchdog
   AST_WAIT_CLK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_WAIT |-> !cpu_clk_en_out && periph_clk_en_out)
      else $error("wait clocks wrong");

   AST_STOP_CLK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_STOP |-> !clk_double_en_out && rec_cnt == 13'h0)
      else $error("stop clocks or counter wrong");

   AST_OSC_STOP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_STOP |-> clk_quad_en_out == cfg_reg[`SLRS_BIT_OSCSTOP])
      else $error("quad clock in stop wrong");

   AST_RUN_CLK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_RUN |-> cpu_clk_en_out && clk_double_en_out && clk_quad_en_out)
      else $error("clocks off while running");

   AST_WAIT_ENTER: assert property (@(posedge mclk_in)
      disable iff (!rst_b_in || any_reset) seq_wait_entry |=> mode == slrs_pkg::SLRS_WAIT)
      else $error("wait not entered");

   AST_WDOG: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_WAIT && !cfg_reg[`SLRS_BIT_WDDIS] |-> watchdog_run_out)
      else $error("watchdog stopped in wait");

   // interrupt mask and wake
   AST_CLR_MASK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_RUN && stop_exec_in |-> clr_int_mask_out)
      else $error("mask not cleared");

   AST_WAIT_MASK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_RUN && wait_exec_in |-> clr_int_mask_out)
      else $error("mask not cleared on wait");

   AST_WAKE: assert property (@(posedge mclk_in) disable iff (!rst_b_in || any_reset)
      mode == slrs_pkg::SLRS_WAIT && irq_pending_in |=> stack_start_out)
      else $error("stacking not one cycle after wake");

   AST_BRK_WAIT: assert property (@(posedge mclk_in)
      disable iff (!rst_b_in || any_reset) seq_wait_break |=> break_during_lowpower_flag
      && mode == slrs_pkg::SLRS_RUN)
      else $error("break in wait not handled");

   // stop and recovery
   AST_STOP_EXIT: assert property (@(posedge mclk_in)
      disable iff (!rst_b_in || any_reset) seq_stop_wake |=> mode == slrs_pkg::SLRS_RECOVER
      && rec_cnt == 13'h0000)
      else $error("stop exit wrong");

   AST_REC_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode != slrs_pkg::SLRS_RECOVER |=> rec_cnt == 13'h0000)
      else $error("recovery counter not held");

   AST_REC_LEN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      seq_rec_end |-> rec_len < rec_span && rec_len + 15'h0004 >= rec_span)
      else $error("recovery length wrong");

   AST_REC_STACK: assert property (@(posedge mclk_in)
      disable iff (!rst_b_in || any_reset) seq_rec_end |=> stack_start_out
      && mode == slrs_pkg::SLRS_RUN)
      else $error("stacking not after recovery");

   AST_EARLY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mode == slrs_pkg::SLRS_RECOVER && !rec_done |=> !stack_start_out)
      else $error("stacking before recovery elapsed");

   // break and flag protection
   AST_SWI: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      break_irq_in && !break_mode |=> force_swi_vector_out)
      else $error("break vector not forced");

   AST_PROTECT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      break_mode && !break_flag_ctrl_reg[`SLRS_BIT_BREAK_CLEAR_ENABLE] |-> !flag_clear_allow_out)
      else $error("flag clear in break");

   AST_FREE_CLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      flag_clear_req_in && !break_mode |-> flag_clear_allow_out)
      else $error("clear refused outside break");

   // reset causes
   AST_RST_RUN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      any_reset |=> mode == slrs_pkg::SLRS_RUN)
      else $error("reset did not end low-power mode");

   AST_RDCLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rd_rstat && rst_sync2 == 8'h00 && !mon_sync2[1] |=> reset_cause_status == 8'h00)
      else $error("status not cleared by read");

   AST_POR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rst_sync2[7] |=> reset_cause_status == `SLRS_RSTAT_POR)
      else $error("power-on flags wrong");

   AST_OTHER_SRC: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !rst_sync2[7] && rst_sync2[6] |=> reset_cause_status[6])
      else $error("pin cause not kept");

   AST_MON_FLAG: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      mon_sync2 == 2'b10 && !rst_sync2[7] |=> reset_cause_status[2])
      else $error("monitor cause not flagged");
endmodule

/* File: tb/slrs_periph_model.sv */
// peripheral status flag with a two-step clear, facing the break flag protection
module slrs_periph_model
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // bench stimulus
   input wire logic set_in,
   input wire logic step1_in,
   input wire logic step2_in,
   // unit side
   input wire logic clear_allow_in,
   output logic clear_req_out,
   output logic flag_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic armed;
   assign clear_req_out = step2_in & armed & flag_out;
   always_ff @(posedge mclk_in)
   begin
      if (!rst_b_in)
      begin
         armed <= 1'b0;
         flag_out <= 1'b0;
      end
      else
      begin
         if (step1_in)
            armed <= 1'b1;
         if (set_in)
            flag_out <= 1'b1;
         // a refused clear keeps step one armed for a later retry
         else if (clear_req_out & clear_allow_in)
         begin
            flag_out <= 1'b0;
            armed <= 1'b0;
         end
      end
   end
endmodule

/* File: tb/tb_slrs_unit.sv */
// self-checking bench for the low-power/reset unit
module tb_slrs_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, wx, sx, irq, brk, cpu, per, dbl, quad, clrm, software_interrupt, stk, bm, wd;
   logic creq, call, vec, tv, srst, fs, f1, f2, flag;
   logic [7:0] rdata, q, cfg;
   slrs_pkg::slrs_bus_t bus;
   slrs_pkg::slrs_rst_src_t src;
   integer seed, error_cnt, n_checks, a, b, k, n;
   slrs_unit i_dut (.mclk_in(clk), .rst_b_in(rst_b), .bus_in(bus), .rdata_out(rdata),
      .wait_exec_in(wx), .stop_exec_in(sx), .irq_pending_in(irq), .break_irq_in(brk),
      .cpu_clk_en_out(cpu), .periph_clk_en_out(per), .clk_double_en_out(dbl),
      .clk_quad_en_out(quad), .clr_int_mask_out(clrm), .force_swi_vector_out(software_interrupt),
      .stack_start_out(stk), .break_mode_out(bm), .watchdog_run_out(wd),
      .flag_clear_req_in(creq), .flag_clear_allow_out(call), .rst_src_in(src),
      .vector_erased_in(vec), .irq_at_test_volt_in(tv), .sys_reset_out(srst));
   slrs_periph_model i_per (.mclk_in(clk), .rst_b_in(rst_b), .set_in(fs), .step1_in(f1),
      .step2_in(f2), .clear_allow_in(call), .clear_req_out(creq), .flag_out(flag));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task acc(input logic w, input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      bus <= '{ad, d, w, !w};
      @(posedge clk);
      bus <= '{4'h0, 8'h00, 1'b0, 1'b0};
      @(negedge clk);
      q = rdata;
   endtask
   // hold a reset cause long enough to pass the synchronisers
   task pulse_src(input logic [7:0] s);
      @(posedge clk);
      src <= s;
      repeat (4) @(negedge clk);
      chk(srst, 1'b1);
      @(posedge clk);
      src <= 8'h00;
      repeat (4) @(negedge clk);
   endtask
   task step2;
      @(posedge clk);
      f2 <= 1'b1;
      @(posedge clk);
      f2 <= 1'b0;
      @(negedge clk);
   endtask
   // one-cycle wait (st = 0) or stop (st = 1) instruction strobe
   task pulse(input logic st);
      @(posedge clk);
      if (st)
         sx <= 1'b1;
      else
         wx <= 1'b1;
      @(negedge clk);
      chk(clrm, 1'b1);
      @(posedge clk);
      {wx, sx} <= 2'b00;
      @(negedge clk);
   endtask
   initial
   begin
      {rst_b, wx, sx, irq, brk, vec, tv, fs, f1, f2} = '0;
      bus = '{4'h0, 8'h00, 1'b0, 1'b0};
      src = 8'h00;
      seed = 57336;
      error_cnt = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      acc(0, 4'h0, 8'h00);
      chk(q, 8'h80);
      acc(0, 4'h0, 8'h00);
      chk(q, 8'h00);
      for (k = 0; k < 4; k++)
      begin
         a = 1 + ({$random(seed)} % 6);
         b = 1 + ({$random(seed)} % 6);
         pulse_src(8'h01 << a);
         pulse_src(8'h01 << b);
         acc(0, 4'h0, 8'h00);
         chk(q, (8'h01 << a) | (8'h01 << b));
      end
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk);
         tv <= k[0];
         vec <= 1'b1;
         repeat (4) @(posedge clk);
         vec <= 1'b0;
         repeat (4) @(posedge clk);
         acc(0, 4'h0, 8'h00);
         chk(q, k[0] ? 8'h00 : 8'h04);
      end
      pulse_src(8'h42);
      pulse_src(8'h80);
      acc(0, 4'h0, 8'h00);
      chk(q, 8'h80);
      acc(1, 4'hf, 8'h5a);
      acc(0, 4'hf, 8'h00);
      chk(q, 8'h00);
      for (k = 0; k < 2; k++)
      begin
         acc(1, 4'h3, k[0] ? 8'h04 : 8'h00);
         pulse(1'b0);
         chk({cpu, per, wd}, {2'b01, !k[0]});
         @(posedge clk);
         irq <= 1'b1;
         repeat (2) @(negedge clk);
         chk({cpu, stk}, 2'b11);
         @(posedge clk);
         irq <= 1'b0;
      end
      for (k = 0; k < 2; k++)
      begin
         cfg = k[0] ? 8'h01 : 8'h02;
         acc(1, 4'h3, cfg);
         pulse(1'b1);
         chk({dbl, per, quad}, {2'b00, cfg[1]});
         @(posedge clk);
         irq <= 1'b1;
         n = 0;
         while (stk !== 1'b1 && n < 20000)
         begin
            @(negedge clk);
            n++;
         end
         if (n == 20000)
         begin
            error_cnt++;
            give_verdict;
         end
         a = cfg[0] ? 128 : 16384;
         chk(n >= a - 4 && n <= a + 8, 1'b1);
         @(posedge clk);
         irq <= 1'b0;
      end
      for (k = 0; k < 2; k++)
      begin
         acc(1, 4'h1, {k[0], 7'h00});
         @(posedge clk);
         {fs, f1} <= 2'b11;
         @(posedge clk);
         {fs, f1, brk} <= 3'b001;
         repeat (2) @(negedge clk);
         chk({software_interrupt, bm}, 2'b11);
         step2;
         chk(flag, !k[0]);
         @(posedge clk);
         brk <= 1'b0;
         repeat (3) @(negedge clk);
         step2;
         chk(flag, 1'b0);
      end
      acc(1, 4'h2, 8'h00);
      pulse(1'b0);
      @(posedge clk);
      brk <= 1'b1;
      repeat (3) @(negedge clk);
      chk(cpu, 1'b1);
      @(posedge clk);
      brk <= 1'b0;
      acc(0, 4'h2, 8'h00);
      chk(q[1], 1'b1);
      give_verdict;
   end
endmodule
